// *** vit_pkg.sv ***
package vit_pkg;
   // ------------------------------------------------------------
   // Code and puncturing
   // ------------------------------------------------------------
   localparam logic [6:0] GEN_A     = 7'h79;  // 171 octal
   localparam logic [6:0] GEN_B     = 7'h5b;  // 133 octal
   localparam int         NUM_RATES = 5;
   localparam logic [2:0] RATE_LAST = 3'h4;
   localparam logic [2:0] SOFT_MAX  = 3'h7;
   // Patterns are stored first position in bit 0
   localparam logic [6:0] PUNC_X [NUM_RATES] = '{7'h01, 7'h03, 7'h03, 7'h0b, 7'h2f};
   localparam logic [6:0] PUNC_Y [NUM_RATES] = '{7'h01, 7'h01, 7'h05, 7'h15, 7'h51};
   localparam logic [2:0] PUNC_LEN [NUM_RATES] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
   // Bit clock factor numerator and denominator per rate
   localparam logic [3:0] CLK_NUM [NUM_RATES] = '{4'h1, 4'h4, 4'h3, 4'h5, 4'h7};
   localparam logic [3:0] CLK_DEN [NUM_RATES] = '{4'h1, 4'h3, 4'h2, 4'h3, 4'h4};

   // ------------------------------------------------------------
   // Sizes and timing
   // ------------------------------------------------------------
   localparam int         SURV_DEPTH = 96;
   localparam int         PM_W       = 12;
   localparam int         SYNC_WIN   = 256;
   localparam int         QUAL_W     = 9;
   localparam int         LOSS_MISS  = 2;
   localparam int         FIFO_DEPTH = 16;
   localparam logic [3:0] BYTE_BITS  = 4'h8;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] thr;
      logic       auto_rate;
      logic [2:0] rate;
   } cfg_t;

   localparam cfg_t CFG_RESET = 8'h48;

   typedef struct packed {
      logic [2:0] i;
      logic [2:0] q;
   } soft_pair_t;

   typedef struct packed {
      logic [2:0] rate;
      logic [1:0] frame;
      logic       rot;
   } hyp_t;
endpackage

// *** vit_core.sv ***
`timescale 1ns/1ps
module vit_core #(
   parameter int DEPTH = vit_pkg::SURV_DEPTH,
   parameter int PM_W  = vit_pkg::PM_W
) (
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_reset_n,
   input  wire logic              i_clk_en,
   // Branch input
   input  wire logic              i_step,
   input  wire logic signed [3:0] i_m0,
   input  wire logic signed [3:0] i_m1,
   // Decoded output
   output logic                   o_bit,
   output logic                   o_valid
);
   localparam int FW = $clog2(DEPTH + 1);

   generate
      if (DEPTH < 8 || PM_W < 8) begin : g_chk
         $error("vit_core: depth or metric width too small");
      end
   endgenerate

   function automatic logic signed [4:0] branch(input logic [6:0] r,
                                                input logic signed [3:0] a,
                                                input logic signed [3:0] b);
      logic signed [4:0] x;
      logic signed [4:0] y;
      x = (^(r & vit_pkg::GEN_A)) ? 5'(a) : -5'(a);
      y = (^(r & vit_pkg::GEN_B)) ? 5'(b) : -5'(b);
      return x + y;
   endfunction

   logic [PM_W-1:0]  pm_r   [64];
   logic [PM_W-1:0]  pm_nxt [64];
   logic [DEPTH-1:0] sv_r   [64];
   logic [DEPTH-1:0] sv_nxt [64];
   logic [FW-1:0]    fill_r;

   // ------------------------------------------------------------
   // Add, compare, select
   // ------------------------------------------------------------
   // Metrics wrap; the signed difference still orders them
   always_comb begin
      logic [5:0]      st;
      logic [5:0]      pa;
      logic [5:0]      pb;
      logic [PM_W-1:0] ma;
      logic [PM_W-1:0] mb;
      st = 6'h00;
      pa = 6'h00;
      pb = 6'h00;
      ma = '0;
      mb = '0;
      for (int s = 0; s < 64; s++) begin
         st = 6'(s);
         pa = {st[4:0], 1'b0};
         pb = {st[4:0], 1'b1};
         ma = pm_r[pa] + PM_W'(branch({st[5], pa}, i_m0, i_m1));  // [R1]
         mb = pm_r[pb] + PM_W'(branch({st[5], pb}, i_m0, i_m1));
         if ($signed(mb - ma) > 0) begin
            pm_nxt[s] = mb;
            sv_nxt[s] = {sv_r[pb][DEPTH-2:0], st[5]};
         end else begin
            pm_nxt[s] = ma;
            sv_nxt[s] = {sv_r[pa][DEPTH-2:0], st[5]};
         end
      end
   end

   // ------------------------------------------------------------
   // Survivor exchange
   // ------------------------------------------------------------
   // One trellis step per enabled clock at most
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int s = 0; s < 64; s++) begin
            pm_r[s] <= '0;
            sv_r[s] <= '0;
         end
         fill_r  <= '0;
         o_bit   <= 1'b0;
         o_valid <= 1'b0;
      end else if (i_clk_en) begin
         o_valid <= i_step && (fill_r == FW'(DEPTH));
         if (i_step) begin
            pm_r   <= pm_nxt;
            sv_r   <= sv_nxt;
            o_bit  <= sv_nxt[0][DEPTH-1];  // [R1]
            if (fill_r != FW'(DEPTH)) begin
               fill_r <= fill_r + 1'b1;
            end
         end
      end
   end
endmodule

// *** vit_sync.sv ***
`timescale 1ns/1ps
module vit_sync #(
   parameter int WIN = vit_pkg::SYNC_WIN
) (
   // Clock and reset
   input  wire logic                        i_core_clk,
   input  wire logic                        i_reset_n,
   input  wire logic                        i_clk_en,
   // Received step
   input  wire logic                        i_step,
   input  wire logic [1:0]                  i_hard,
   input  wire logic [1:0]                  i_seen,
   // Control
   input  wire vit_pkg::cfg_t               i_cfg,
   // Result
   output vit_pkg::hyp_t                    o_hyp,
   output logic                             o_lock,
   output logic                             o_next,
   output logic [vit_pkg::QUAL_W-1:0]       o_qual
);
   localparam int CW = $clog2(WIN + 1);

   generate
      if (WIN < 16 || (1 << $clog2(WIN)) != WIN || CW > vit_pkg::QUAL_W) begin : g_chk
         $error("vit_sync: window must be a power of two from 16 to 256");
      end
   endgenerate

   logic [6:0]    sa_r;
   logic [6:0]    sb_r;
   logic [CW-1:0] win_r;
   logic [CW-1:0] err_r;
   logic [1:0]    miss_r;
   logic [2:0]    fr_nxt;

   // Erased positions enter as zero; a limitation at high rates
   wire [6:0]    sa_nxt   = {i_hard[0] & i_seen[0], sa_r[6:1]};
   wire [6:0]    sb_nxt   = {i_hard[1] & i_seen[1], sb_r[6:1]};
   wire          syn      = ^(sa_nxt & vit_pkg::GEN_B) ^ ^(sb_nxt & vit_pkg::GEN_A);  // [R12]
   wire [CW-1:0] err_nxt  = err_r + CW'(syn);
   wire          win_end  = i_step && (win_r == CW'(WIN - 1));
   wire [CW-1:0] thr_cnt  = CW'({5'h00, i_cfg.thr} << ($clog2(WIN) - 4));
   wire          good     = err_nxt < thr_cnt;  // [R15]
   wire [2:0]    fix_rate = (i_cfg.rate > vit_pkg::RATE_LAST) ? 3'h0 : i_cfg.rate;
   wire          give_up  = !good && (!o_lock || miss_r == 2'(vit_pkg::LOSS_MISS - 1));

   // Step rotation first, then framing, then rate
   assign fr_nxt = {o_hyp.frame, o_hyp.rot} + 3'h1;  // [R13] [R14]

   // ------------------------------------------------------------
   // Hypothesis search
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sa_r   <= 7'h00;
         sb_r   <= 7'h00;
         win_r  <= '0;
         err_r  <= '0;
         miss_r <= 2'h0;
         o_hyp  <= '0;
         o_lock <= 1'b0;
         o_next <= 1'b0;
         o_qual <= '0;
      end else if (i_clk_en) begin
         o_next <= win_end && give_up;
         if (i_step) begin
            sa_r  <= sa_nxt;
            sb_r  <= sb_nxt;
            win_r <= win_end ? '0 : win_r + 1'b1;
            err_r <= win_end ? '0 : err_nxt;
         end
         if (win_end) begin
            o_qual <= vit_pkg::QUAL_W'(err_nxt);  // [R17]
            if (good) begin
               o_lock <= 1'b1;  // [R16]
               miss_r <= 2'h0;
            end else if (!give_up) begin
               miss_r <= miss_r + 2'h1;
            end else begin
               o_lock               <= 1'b0;
               miss_r               <= 2'h0;
               {o_hyp.frame, o_hyp.rot} <= fr_nxt;  // [R15]
               if (fr_nxt == 3'h0 && i_cfg.auto_rate) begin
                  o_hyp.rate <= (o_hyp.rate == vit_pkg::RATE_LAST) ? 3'h0 : o_hyp.rate + 3'h1;  // [R17]
               end
            end
         end
         // Manual rate change voids lock
         if (!i_cfg.auto_rate && fix_rate != o_hyp.rate) begin
            o_hyp.rate <= fix_rate;
            o_lock     <= 1'b0;
         end
      end
   end
endmodule

// *** punctured_viterbi_decoder.sv ***
// What this block does
// [R1] K=7 Viterbi, 171/133 octal, depth 96
// [R2] Five puncture patterns per rate table
// [R3] Ones are received, zeros are reinserted
// [R4] Reinserted positions carry neutral soft value
// [R5] Demodulator gives 3-bit I, Q, clock
// [R6] FIFO written on symbol, read on bit
// [R7] FIFO full and empty flags driven out
// [R8] Bit clock derived from symbol clock
// [R9] Bit rate factor 1,4/3,3/2,5/3,7/4
// [R10] Sustain 50 Mbit/s decoded output
// [R11] No valid data before synchronization
// [R12] Syndrome product nonzeros measure errors
// [R13] Try I/Q unrotated and rotated 90
// [R14] Search four framings of I/Q streams
// [R15] Step hypotheses, keep while errors low
// [R16] Lock flag once acquisition succeeds
// [R17] Automatic rate choice and quality output
// [R18] Selected rate on 3-bit output
// [R19] Settings programmable over I2C slave
// [R20] Reset defaults allow unconfigured operation
// [R21] Slave address from seven pins
// [R22] Active-low asynchronous reset initializes all; the FIFO storage mem_r has no reset
// [R23] Output symbol clock divided by two
`timescale 1ns/1ps
module punctured_viterbi_decoder #(
   parameter int FIFO_DEPTH = vit_pkg::FIFO_DEPTH
) (
   // Clock, reset, enable
   input  wire logic                        i_core_clk,
   input  wire logic                        i_reset_n,
   input  wire logic                        i_clk_en,
   // Demodulator
   input  wire logic                        i_demod_symbol_clock,
   input  wire logic [2:0]                  i_soft_in_i,
   input  wire logic [2:0]                  i_soft_in_q,
   // I2C slave
   input  wire logic                        i_scl,
   input  wire logic                        i_sda,
   output logic                             o_sda_out,
   output logic                             o_sda_oe,
   input  wire logic [6:0]                  i_slave_address_pins,
   // Decoded stream
   output logic                             o_decoded_bit_clock,
   output logic                             o_decoded_bit_out,
   output logic                             o_symbol_clock_half,
   // Status
   output logic                             o_lock_flag,
   output logic                             o_fifo_full_flag,
   output logic                             o_fifo_empty_flag,
   output logic [2:0]                       o_selected_rate_out,
   output logic [vit_pkg::QUAL_W-1:0]       o_signal_quality
);
   localparam int AW = $clog2(FIFO_DEPTH);

   generate
      if (FIFO_DEPTH < 4 || (1 << AW) != FIFO_DEPTH) begin : g_chk
         $error("punctured_viterbi_decoder: FIFO depth must be a power of two");
      end
   endgenerate

   typedef enum {I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WR, I2C_WACK, I2C_RD, I2C_RACK} i2c_st_t;

   function automatic logic signed [3:0] soft_metric(input logic [2:0] s, input logic seen);
      return seen ? 4'($signed({1'b0, s, 1'b0}) - 5'sd7) : 4'sd0;
   endfunction

   vit_pkg::cfg_t       cfg_r;
   vit_pkg::hyp_t       hyp;
   vit_pkg::soft_pair_t mem_r [FIFO_DEPTH];
   logic                lock;
   logic                next;
   logic [vit_pkg::QUAL_W-1:0] qual;
   logic                core_bit;
   logic                core_valid;

   logic                sym_d_r;
   logic [3:0]          acc_r;
   logic                tick_d_r;
   logic [AW:0]         wp_r;
   logic [AW:0]         rp_r;
   logic [11:0]         q_r;
   logic [2:0]          qc_r;
   logic [2:0]          k_r;

   // ------------------------------------------------------------
   // Symbol clock and bit clock
   // ------------------------------------------------------------
   wire       sym_rise = i_demod_symbol_clock & ~sym_d_r;  // [R5]
   wire [2:0] rate     = hyp.rate;
   wire [3:0] num      = vit_pkg::CLK_NUM[rate];  // [R9]
   wire [3:0] den      = vit_pkg::CLK_DEN[rate];
   wire       tick     = acc_r >= den;  // [R8]
   wire [3:0] acc_nxt  = acc_r + (sym_rise ? num : 4'h0) - (tick ? den : 4'h0);  // [R9]

   // ------------------------------------------------------------
   // Input FIFO
   // ------------------------------------------------------------
   wire full   = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);  // [R7]
   wire empty  = wp_r == rp_r;  // [R7]
   wire push   = sym_rise && !full;  // [R6]
   vit_pkg::soft_pair_t rd;
   assign rd   = mem_r[rp_r[AW-1:0]];

   // Rotation by 90 degrees maps (I,Q) to (Q,-I)
   wire [2:0] rot_a = hyp.rot ? rd.q : rd.i;  // [R13]
   wire [2:0] rot_b = hyp.rot ? vit_pkg::SOFT_MAX - rd.i : rd.q;
   wire [2:0] fst   = hyp.frame[0] ? rot_b : rot_a;  // [R14]
   wire [2:0] snd   = hyp.frame[0] ? rot_a : rot_b;

   // ------------------------------------------------------------
   // Depuncturing
   // ------------------------------------------------------------
   wire       px     = vit_pkg::PUNC_X[rate][k_r];  // [R2]
   wire       py     = vit_pkg::PUNC_Y[rate][k_r];
   wire [2:0] need   = {2'h0, px} + {2'h0, py};
   // A hypothesis change slips the stream by one soft value when at least one is queued
   wire       slip   = next && (qc_r != 3'h0);  // [R14]
   wire       step   = tick && !next && (qc_r >= need);
   wire [2:0] drop   = slip ? 3'h1 : (step ? need : 3'h0);
   wire [2:0] cnt_af = qc_r - drop;
   wire       pop    = tick && !empty && (cnt_af <= 3'h2);  // [R6]
   wire [2:0] sym_x  = q_r[2:0];
   wire [2:0] sym_y  = px ? q_r[5:3] : q_r[2:0];
   wire [11:0] q_sh  = q_r >> (drop * 3'h3);
   wire [11:0] q_nxt = q_sh | (pop ? (12'({snd, fst}) << (cnt_af * 4'h3)) : 12'h000);
   wire [2:0] qc_nxt = cnt_af + (pop ? 3'h2 : 3'h0);
   wire signed [3:0] m0 = soft_metric(sym_x, px);  // [R3] [R4]
   wire signed [3:0] m1 = soft_metric(sym_y, py);  // [R3] [R4]
   wire [2:0] k_last = vit_pkg::PUNC_LEN[rate] - 3'h1;

   // ------------------------------------------------------------
   // Datapath registers
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_clk_en && push) begin
         mem_r[wp_r[AW-1:0]] <= '{i: i_soft_in_i, q: i_soft_in_q};  // [R6]
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin  // [R22]
         sym_d_r <= 1'b0;
         acc_r   <= 4'h0;
         wp_r    <= '0;
         rp_r    <= '0;
         q_r     <= 12'h000;
         qc_r    <= 3'h0;
         k_r     <= 3'h0;
      end else if (i_clk_en) begin
         sym_d_r <= i_demod_symbol_clock;
         acc_r   <= acc_nxt;
         q_r     <= q_nxt;
         qc_r    <= qc_nxt;
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (next) begin
            k_r <= 3'h0;
         end else if (step) begin
            k_r <= (k_r >= k_last) ? 3'h0 : k_r + 3'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Decoder core and synchronizer
   // ------------------------------------------------------------
   vit_core #(
      .DEPTH (vit_pkg::SURV_DEPTH),
      .PM_W  (vit_pkg::PM_W)
   ) u_core (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_clk_en   (i_clk_en),
      .i_step     (step),
      .i_m0       (m0),
      .i_m1       (m1),
      .o_bit      (core_bit),
      .o_valid    (core_valid)
   );

   vit_sync #(
      .WIN (vit_pkg::SYNC_WIN)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_clk_en   (i_clk_en),
      .i_step     (step),
      .i_hard     ({sym_y[2], sym_x[2]}),
      .i_seen     ({py, px}),
      .i_cfg      (cfg_r),
      .o_hyp      (hyp),
      .o_lock     (lock),
      .o_next     (next),
      .o_qual     (qual)
   );

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   // Bit clock is delayed two edges to line up with core data
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tick_d_r            <= 1'b0;
         o_decoded_bit_clock <= 1'b0;
         o_decoded_bit_out   <= 1'b0;
         o_symbol_clock_half <= 1'b0;
         o_lock_flag         <= 1'b0;
         o_fifo_full_flag    <= 1'b0;
         o_fifo_empty_flag   <= 1'b1;
         o_selected_rate_out <= 3'h0;
         o_signal_quality    <= '0;
      end else if (i_clk_en) begin
         tick_d_r            <= tick;
         o_decoded_bit_clock <= tick_d_r;  // [R8]
         if (!lock) begin
            o_decoded_bit_out <= 1'b0;  // [R11]
         end else if (core_valid) begin
            o_decoded_bit_out <= core_bit;  // [R10]
         end
         if (sym_rise) begin
            o_symbol_clock_half <= ~o_symbol_clock_half;  // [R23]
         end
         o_lock_flag         <= lock;  // [R16]
         o_fifo_full_flag    <= full;  // [R7]
         o_fifo_empty_flag   <= empty;
         o_selected_rate_out <= rate;  // [R18]
         o_signal_quality    <= qual;  // [R17]
      end
   end

   // ------------------------------------------------------------
   // I2C slave
   // ------------------------------------------------------------
   i2c_st_t    st_r;
   logic       scl_r;
   logic       sda_r;
   logic       scl_p;
   logic       sda_p;
   logic [7:0] sh_r;
   logic [3:0] bc_r;
   logic       rw_r;

   wire       i2c_start = scl_r & scl_p & sda_p & ~sda_r;
   wire       i2c_stop  = scl_r & scl_p & ~sda_p & sda_r;
   wire       scl_rise  = scl_r & ~scl_p;
   wire       scl_fall  = ~scl_r & scl_p;
   wire       byte_done = bc_r == vit_pkg::BYTE_BITS;
   wire       addr_hit  = sh_r[7:1] == i_slave_address_pins;  // [R21]
   wire [7:0] status    = {lock, hyp.rate, qual[vit_pkg::QUAL_W-1 -: 4]};

   // Open drain: only ever pulls low
   assign o_sda_out = 1'b0;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r     <= I2C_IDLE;
         {scl_r, sda_r, scl_p, sda_p} <= 4'hf;
         sh_r     <= 8'h00;
         bc_r     <= 4'h0;
         rw_r     <= 1'b0;
         o_sda_oe <= 1'b0;
         cfg_r    <= vit_pkg::CFG_RESET;  // [R20]
      end else if (i_clk_en) begin
         {scl_p, sda_p} <= {scl_r, sda_r};
         {scl_r, sda_r} <= {i_scl, i_sda};
         if (i2c_start || i2c_stop) begin
            st_r     <= i2c_start ? I2C_ADDR : I2C_IDLE;
            bc_r     <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (scl_rise) begin
            unique case (st_r)
               I2C_ADDR, I2C_WR: begin
                  sh_r <= {sh_r[6:0], sda_r};
                  bc_r <= bc_r + 4'h1;
               end
               I2C_RD: begin
                  sh_r <= {sh_r[6:0], 1'b0};
                  bc_r <= bc_r + 4'h1;
               end
               I2C_RACK: begin
                  if (sda_r) begin
                     st_r <= I2C_IDLE;
                  end
               end
               I2C_IDLE, I2C_AACK, I2C_WACK: begin
               end
            endcase
         end else if (scl_fall) begin
            unique case (st_r)
               I2C_ADDR: begin
                  if (byte_done) begin
                     st_r     <= addr_hit ? I2C_AACK : I2C_IDLE;
                     o_sda_oe <= addr_hit;
                     rw_r     <= sh_r[0];
                  end
               end
               I2C_AACK, I2C_RACK: begin
                  bc_r     <= 4'h0;
                  st_r     <= rw_r ? I2C_RD : I2C_WR;
                  sh_r     <= status;
                  o_sda_oe <= rw_r && !status[7];
               end
               I2C_WR: begin
                  if (byte_done) begin
                     cfg_r    <= sh_r;  // [R19]
                     o_sda_oe <= 1'b1;
                     st_r     <= I2C_WACK;
                  end
               end
               I2C_WACK: begin
                  bc_r     <= 4'h0;
                  o_sda_oe <= 1'b0;
                  st_r     <= I2C_WR;
               end
               I2C_RD: begin
                  o_sda_oe <= !byte_done && !sh_r[7];
                  if (byte_done) begin
                     st_r <= I2C_RACK;
                  end
               end
               I2C_IDLE: begin
               end
            endcase
         end
      end
   end

endmodule

// *** vit_monitor.sv ***
`timescale 1ns/1ps
module vit_monitor (
   // Clock and inputs
   input wire logic                        i_core_clk,
   input wire logic                        i_reset_n,
   input wire logic                        i_clk_en,
   input wire logic                        i_demod_symbol_clock,
   // Outputs watched
   input wire logic                        o_decoded_bit_clock,
   input wire logic                        o_decoded_bit_out,
   input wire logic                        o_symbol_clock_half,
   input wire logic                        o_lock_flag,
   input wire logic                        o_fifo_full_flag,
   input wire logic                        o_fifo_empty_flag,
   input wire logic [2:0]                  o_selected_rate_out,
   input wire logic [vit_pkg::QUAL_W-1:0]  o_signal_quality
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);
   unlocked_zero_a: assert property (!o_lock_flag |-> !o_decoded_bit_out)
      else $error("decoded bit high while unlocked");
   bit_hold_a: assert property ($changed(o_decoded_bit_out) |-> o_decoded_bit_clock || !o_lock_flag)
      else $error("decoded bit moved without a pulse");
   rate_range_a: assert property (o_selected_rate_out <= 3'h4)
      else $error("rate code out of range");
   rate_kept_a: assert property (o_lock_flag && $past(o_lock_flag) |-> $stable(o_selected_rate_out))
      else $error("rate changed while locked");
   flags_excl_a: assert property (!(o_fifo_full_flag && o_fifo_empty_flag))
      else $error("fifo full and empty together");
   half_toggle_a: assert property ($changed(o_symbol_clock_half) |->
      $past(i_demod_symbol_clock) && !$past(i_demod_symbol_clock, 2))
      else $error("half clock toggled without symbol edge");
   qual_range_a: assert property (o_signal_quality <= 9'h100)
      else $error("quality above window size");
   state_freeze_a: assert property (!i_clk_en |=> $stable(o_lock_flag) && $stable(o_symbol_clock_half))
      else $error("state moved while disabled");
   lock_c: cover property ($rose(o_lock_flag));
   pulse_c: cover property (o_decoded_bit_clock && o_decoded_bit_out);
   fill_c: cover property ($fell(o_fifo_empty_flag));
endmodule
bind punctured_viterbi_decoder vit_monitor mon_u (.i_core_clk, .i_reset_n, .i_clk_en, .i_demod_symbol_clock,
   .o_decoded_bit_clock, .o_decoded_bit_out, .o_symbol_clock_half, .o_lock_flag, .o_fifo_full_flag,
   .o_fifo_empty_flag, .o_selected_rate_out, .o_signal_quality);

// *** demod_model.sv ***
`timescale 1ns/1ps
module demod_model (
   // Clock and control
   input  wire logic  i_clk,
   input  wire logic  i_reset_n,
   input  wire logic  i_run,
   // Soft symbols
   output logic       o_sym_clk,
   output logic [2:0] o_soft_i,
   output logic [2:0] o_soft_q
);
   logic [5:0]  hist_r;
   logic [15:0] lfsr_r;
   logic [6:0]  win;
   assign win = {lfsr_r[0], hist_r};
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hist_r    <= 6'h00;
         lfsr_r    <= 16'h0001;
         o_sym_clk <= 1'b0;
         o_soft_i  <= 3'h0;
         o_soft_q  <= 3'h0;
      end else if (i_run && !o_sym_clk) begin
         // Data rises with the clock and holds through the high phase
         o_sym_clk <= 1'b1;
         o_soft_i  <= {3{^(win & vit_pkg::GEN_A)}};
         o_soft_q  <= {3{^(win & vit_pkg::GEN_B)}};
         hist_r    <= win[6:1];
         lfsr_r    <= {lfsr_r[0] ^ lfsr_r[2] ^ lfsr_r[3] ^ lfsr_r[5], lfsr_r[15:1]};
      end else begin
         o_sym_clk <= 1'b0;
         if (!i_run) begin
            // Stopped stream: no stale value left on the lines
            o_soft_i <= ~o_soft_i;
            o_soft_q <= ~o_soft_q;
         end
      end
   end
endmodule

// *** tb_punctured_viterbi_decoder.sv ***
`timescale 1ns/1ps
module tb_punctured_viterbi_decoder;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       en = 1'b0;
   logic       run = 1'b0;
   logic       sym, bclk, bout, half, lock, full, empty, oe;
   logic       scl = 1'b1, sda = 1'b1;
   logic [2:0] si, sq, rate;
   logic [8:0] qual;
   int         fail_count = 0;
   int         n_compared = 0;
   always #50 clk = ~clk;
   demod_model pm_u (.i_clk(clk), .i_reset_n(rst_n), .i_run(run), .o_sym_clk(sym), .o_soft_i(si), .o_soft_q(sq));
   punctured_viterbi_decoder dut_u (.i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(en),
      .i_demod_symbol_clock(sym), .i_soft_in_i(si), .i_soft_in_q(sq), .i_scl(scl), .i_sda(sda & ~oe),
      .o_sda_out(), .o_sda_oe(oe), .i_slave_address_pins(7'h2a), .o_decoded_bit_clock(bclk),
      .o_decoded_bit_out(bout), .o_symbol_clock_half(half), .o_lock_flag(lock), .o_fifo_full_flag(full),
      .o_fifo_empty_flag(empty), .o_selected_rate_out(rate), .o_signal_quality(qual));
   task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Bounded wait; a miss ends the run
   task automatic wait_sig(string what, int lim, ref logic s, input logic v);
      for (int k = 0; k < lim && s !== v; k++) @(negedge clk);
      chk(what, {8'h00, v}, {8'h00, s});
      if (s !== v) finish_test();
   endtask
   task automatic t_reset();
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("empty in reset", 9'h001, {8'h00, empty});
      chk("lock in reset", 9'h000, {8'h00, lock});
      @(posedge clk);
      rst_n <= 1'b1;
      en    <= 1'b1;
      repeat (2) @(posedge clk);
      run <= 1'b1;
      wait_sig("empty after fill", 8, empty, 1'b0);
   endtask
   task automatic t_lock();
      wait_sig("lock", 40000, lock, 1'b1);
      chk("rate", 9'h000, {6'h00, rate});
      chk("quality low", 9'h001, {8'h00, qual < 9'h040});
   endtask
   // 400 cycles carry 200 symbols at rate 1/2
   task automatic t_rate();
      int n;
      int ones;
      n = 0;
      ones = 0;
      repeat (400) begin
         @(negedge clk);
         n += int'(bclk);
         ones += int'(bclk & bout);
      end
      chk("bits per window", 9'h001, {8'h00, n >= 199 && n <= 201});
      chk("both bit values", 9'h001, {8'h00, ones > 0 && ones < n});
   endtask
   task automatic t_pause();
      @(posedge clk);
      en <= 1'b0;
      repeat (6) @(posedge clk);
      en <= 1'b1;
      @(negedge clk);
      chk("lock after pause", 9'h001, {8'h00, lock});
      @(posedge clk);
      run <= 1'b0;
      wait_sig("empty after stop", 40, empty, 1'b1);
   endtask
   // Config write: auto off, rate 2/3
   task automatic t_i2c();
      logic [17:0] f;
      logic [1:0]  nack;
      f = {7'h2a, 1'b0, 1'b1, 8'h41, 1'b1};
      sda <= 1'b0;
      repeat (4) @(posedge clk);
      for (int k = 17; k >= -1; k--) begin
         scl <= 1'b0;
         repeat (2) @(posedge clk);
         sda <= (k < 0) ? 1'b0 : f[k];
         repeat (4) @(posedge clk);
         scl <= 1'b1;
         repeat (4) @(posedge clk);
         if (k % 9 == 0) nack = {nack[0], sda & ~oe};
      end
      sda <= 1'b1;
      repeat (4) @(posedge clk);
      chk("i2c acks", 9'h000, {7'h00, nack});
      chk("fixed rate", 9'h001, {6'h00, rate});
   endtask
   initial begin
      t_reset();
      t_lock();
      t_rate();
      t_pause();
      t_i2c();
      finish_test();
   end
endmodule
